// ---- logic/cmag_gate.sv ----
// Purpose: Control mode holder and command access gate for the amplifier
// Assumes: Panel and serial strobes are one cycle, from the clock_i domain
// Notes: Parallel inhibit and fault inputs are pins, synchronised here
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module cmag_gate
  import cmag_pkg::*;
#(
  parameter logic [3:0] OPT_UNITS = 4'h0 // Installed options strap
) (
  input wire logic clock_i,             // System clock
  input wire logic sys_rst_i,           // Async reset, active high
  input wire logic [3:0] addr_i,        // Register address
  input wire logic [31:0] wdata_i,      // Register write data
  input wire logic wr_i,                // Write strobe
  input wire logic rd_i,                // Read strobe
  output logic [31:0] rdata_o,          // Read data, next cycle
  output logic irq_o,                   // Level interrupt
  input wire logic panel_present_i,     // Panel attached
  input wire cmag_panel_s panel_i,      // Panel request strobes
  input wire logic ser_cmd_i,           // Serial control command strobe
  input wire logic ser_lockout_i,       // Serial set local lockout
  input wire logic ser_unlock_i,        // Serial remove local lockout
  input wire logic ser_query_i,         // Serial query strobe
  input wire logic [15:0] ser_msg_i,    // Query message code
  input wire logic pio_cmd_i,           // Parallel control command strobe
  input wire logic pio_inhibit_i,       // Parallel inhibit pin
  input wire logic pio_fault_in_i,      // Parallel fault pin
  input wire logic thermal_i,           // Thermal shutdown fault
  input wire logic overcur_i,           // Overcurrent shutdown fault
  input wire logic fault_any_i,         // Any fault present
  input wire logic mute_clear_i,        // Panel request to unmute
  output cmag_reply_s reply_o,          // Serial query answer
  output logic ser_cmd_ok_o,            // Serial command accepted
  output logic pio_cmd_ok_o,            // Parallel command accepted
  output logic panel_ok_o,              // Panel change accepted
  output logic mute_o,                  // Amplifier output off
  output logic pio_fault_o,             // Fault request from parallel pin
  output logic pio_fault_rpt_o,         // Fault shown on parallel outputs
  output logic [CMAG_PIO_W-1:0] pio_out_o, // Parallel status outputs
  output cmag_mode_e mode_o             // Current control mode
);

  cmag_state_s q_ff;
  cmag_state_s nxt_q;

  // Encode mode for the reply
  function automatic logic [7:0] mode_code(input cmag_mode_e m);
    unique case (m)
      CMAG_REMOTE: mode_code = CMAG_CODE_REMOTE;
      CMAG_LOCAL: mode_code = CMAG_CODE_LOCAL;
      CMAG_MAINT: mode_code = CMAG_CODE_MAINT;
      default: mode_code = CMAG_CODE_REMOTE;
    endcase
  endfunction

  logic inh_s;
  logic fin_s;
  logic pan_block;
  logic pan_req;
  logic pan_change;
  logic mode_chg;
  logic pw_active;
  logic mute_set;
  logic [CMAG_EV_W-1:0] ev;

  // Next state
  always_comb begin
    nxt_q = q_ff;
    inh_s = q_ff.inh_sync[1];
    fin_s = q_ff.fin_sync[1];
    nxt_q.inh_sync = {q_ff.inh_sync[0], pio_inhibit_i};
    nxt_q.fin_sync = {q_ff.fin_sync[0], pio_fault_in_i};
    // Password gate is live when password enabled, or when lockout is on with a password set
    pw_active = q_ff.ctrl[CMAG_CTL_PWEN] |
                (q_ff.lockout & q_ff.ctrl[CMAG_CTL_PWSET]);
    // Panel blocked under lockout or password enable unless unlocked by password
    pan_block = ((q_ff.lockout | q_ff.ctrl[CMAG_CTL_PWEN]) &
                 ~(pw_active & q_ff.unlocked));
    pan_req = panel_i.key_inc | panel_i.key_dec | panel_i.sel_maint;
    // Remote-disables-local still allows the mode itself to move
    pan_change = panel_i.change & panel_present_i & ~pan_block &
                 ~(q_ff.mode == CMAG_REMOTE & q_ff.ctrl[CMAG_CTL_RDL]);
    mode_chg = 1'b0;
    // Mode transitions only from the panel
    if (!panel_present_i) begin
      nxt_q.mode = CMAG_REMOTE;
      mode_chg = (q_ff.mode != CMAG_REMOTE);
    end else if (pan_req && !pan_block) begin
      if (panel_i.sel_maint) begin
        nxt_q.mode = CMAG_MAINT;
      end else if (q_ff.mode == CMAG_REMOTE) begin
        nxt_q.mode = CMAG_LOCAL;
      end else begin
        nxt_q.mode = CMAG_REMOTE;
      end
      mode_chg = (nxt_q.mode != q_ff.mode);
    end
    // Lockout only taken in remote mode
    if (ser_unlock_i) begin
      nxt_q.lockout = 1'b0;
    end else if (ser_lockout_i && q_ff.mode == CMAG_REMOTE) begin
      nxt_q.lockout = 1'b1;
    end
    if (panel_i.pw_ok && q_ff.ctrl[CMAG_CTL_PWSET]) begin
      nxt_q.unlocked = 1'b1;
    end else if (panel_i.pw_relock) begin
      nxt_q.unlocked = 1'b0;
    end
    // Access grants
    nxt_q.ser_ok = ser_cmd_i & (q_ff.mode == CMAG_REMOTE);
    nxt_q.pio_ok = pio_cmd_i & (q_ff.mode == CMAG_REMOTE);
    nxt_q.pan_ok = pan_change;
    // Fault input acts in every mode
    nxt_q.pio_flt = fin_s & q_ff.ctrl[CMAG_CTL_FI_EN];
    // Mute handling
    mute_set = 1'b0;
    if (q_ff.ctrl[CMAG_CTL_INH_EN] && inh_s) begin
      mute_set = 1'b1;
      if (q_ff.mode == CMAG_MAINT) begin
        nxt_q.inh_latch = 1'b1;
      end
    end
    if (q_ff.mode == CMAG_MAINT && (thermal_i || overcur_i)) begin
      mute_set = 1'b1;
    end
    if (mute_clear_i && pan_change && !mute_set) begin
      nxt_q.inh_latch = 1'b0;
    end
    nxt_q.mute = mute_set | nxt_q.inh_latch;
    // Parallel status outputs per selection bit
    for (int i = 0; i < CMAG_PIO_W; i++) begin
      nxt_q.pio_out[i] = q_ff.piosel[i] ? (q_ff.mode == CMAG_MAINT) :
                         (q_ff.mode == CMAG_LOCAL);
    end
    // Hide faults on parallel outputs in maintenance; uses the next mode
    // so the flop never shows a fault in the first maintenance cycle
    nxt_q.pio_rpt = fault_any_i & (nxt_q.mode != CMAG_MAINT);
    // Reply message and data hold between answers; valid drops after one cycle
    nxt_q.reply.valid = 1'b0;
    nxt_q.reply.msg = q_ff.reply.msg;
    nxt_q.reply.data = q_ff.reply.data;
    // Queries answered in any mode, never alter state
    if (ser_query_i) begin
      if (ser_msg_i == {8'h00, CMAG_MSG_MODE_QUERY}) begin
        nxt_q.reply.valid = 1'b1;
        nxt_q.reply.msg = ser_msg_i;
        nxt_q.reply.data = mode_code(q_ff.mode);
      end else if (ser_msg_i == CMAG_MSG_OPT_QUERY) begin
        nxt_q.reply.valid = 1'b1;
        nxt_q.reply.msg = ser_msg_i;
        nxt_q.reply.data = {4'h0, OPT_UNITS};
      end
    end
    // Events; set wins over read clear
    ev = '0;
    ev[CMAG_EV_MODE] = mode_chg;
    ev[CMAG_EV_REJ] = (panel_i.change | pan_req) & pan_block;
    ev[CMAG_EV_MUTE] = mute_set & ~q_ff.mute;
    if (rd_i && addr_i == CMAG_REG_IRQ) begin
      nxt_q.irq = ev;
    end else begin
      nxt_q.irq = q_ff.irq | ev;
    end
    // Register writes
    if (wr_i) begin
      unique case (addr_i)
        CMAG_REG_CTRL: nxt_q.ctrl = wdata_i[CMAG_CTL_W-1:0];
        CMAG_REG_MASK: nxt_q.mask = wdata_i[CMAG_EV_W-1:0];
        CMAG_REG_PIOSEL: nxt_q.piosel = wdata_i[CMAG_PIO_W-1:0];
        default: ;
      endcase
    end
    // Register reads, unmapped reads as zero
    nxt_q.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        CMAG_REG_CTRL: nxt_q.rdata = {{(32-CMAG_CTL_W){1'b0}}, q_ff.ctrl};
        CMAG_REG_STAT: nxt_q.rdata = {24'h0, q_ff.lockout, q_ff.unlocked,
                                      q_ff.inh_latch, q_ff.mute,
                                      q_ff.mode, panel_present_i};
        CMAG_REG_IRQ: nxt_q.rdata = {{(32-CMAG_EV_W){1'b0}}, q_ff.irq};
        CMAG_REG_MASK: nxt_q.rdata = {{(32-CMAG_EV_W){1'b0}}, q_ff.mask};
        CMAG_REG_PIOSEL: nxt_q.rdata = {{(32-CMAG_PIO_W){1'b0}}, q_ff.piosel};
        default: nxt_q.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_ff <= '{mode: CMAG_REMOTE, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs
  assign rdata_o = q_ff.rdata;
  assign irq_o = |(q_ff.irq & q_ff.mask);
  assign reply_o = q_ff.reply;
  assign ser_cmd_ok_o = q_ff.ser_ok;
  assign pio_cmd_ok_o = q_ff.pio_ok;
  assign panel_ok_o = q_ff.pan_ok;
  assign mute_o = q_ff.mute;
  assign pio_fault_o = q_ff.pio_flt;
  // Service request lives outside this block and stays unaffected
  assign pio_fault_rpt_o = q_ff.pio_rpt;
  assign pio_out_o = q_ff.pio_out;
  assign mode_o = q_ff.mode;

  // Remote commands never pass outside remote mode
  property p_ser_gate;
    @(posedge clock_i) disable iff (sys_rst_i)
      ser_cmd_i && q_ff.mode != CMAG_REMOTE |=> !ser_cmd_ok_o;
  endproperty
  a_ser_gate: assert property (p_ser_gate) else $error("serial passed");

  property p_pio_gate;
    @(posedge clock_i) disable iff (sys_rst_i)
      pio_cmd_i && q_ff.mode == CMAG_REMOTE |=> pio_cmd_ok_o;
  endproperty
  a_pio_gate: assert property (p_pio_gate) else $error("pio dropped");

  property p_no_panel;
    @(posedge clock_i) disable iff (sys_rst_i)
      !panel_present_i |=> mode_o == CMAG_REMOTE;
  endproperty
  a_no_panel: assert property (p_no_panel) else $error("no panel");

  property p_mode_src;
    @(posedge clock_i) disable iff (sys_rst_i)
      !pan_req && panel_present_i |=> $stable(mode_o);
  endproperty
  a_mode_src: assert property (p_mode_src) else $error("mode moved");

  property p_key_toggle;
    @(posedge clock_i) disable iff (sys_rst_i)
      panel_i.key_inc && !panel_i.sel_maint && !pan_block &&
      panel_present_i |=> mode_o != CMAG_MAINT;
  endproperty
  a_key_toggle: assert property (p_key_toggle) else $error("key mnt");

  property p_maint_mute;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.mode == CMAG_MAINT && thermal_i |=> mute_o;
  endproperty
  a_maint_mute: assert property (p_maint_mute) else $error("no mute");

  property p_inh_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.inh_latch && !mute_clear_i |=> mute_o;
  endproperty
  a_inh_hold: assert property (p_inh_hold) else $error("inhibit lost");

  property p_mode_reply;
    @(posedge clock_i) disable iff (sys_rst_i)
      ser_query_i && ser_msg_i == {8'h00, CMAG_MSG_MODE_QUERY} |=>
        reply_o.valid && reply_o.data == mode_code($past(q_ff.mode));
  endproperty
  a_mode_reply: assert property (p_mode_reply) else $error("reply");

  property p_lock;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.lockout && !q_ff.unlocked && panel_i.change |=> !panel_ok_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout bypassed");

  property p_maint_rpt;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.mode == CMAG_MAINT |-> !pio_fault_rpt_o;
  endproperty
  a_maint_rpt: assert property (p_maint_rpt) else $error("fault out");

  // Serial commands pass in remote mode
  property p_ser_pass;
    @(posedge clock_i) disable iff (sys_rst_i)
      ser_cmd_i && q_ff.mode == CMAG_REMOTE |=> ser_cmd_ok_o;
  endproperty
  a_ser_pass: assert property (p_ser_pass) else $error("serial lost");

  property p_pio_block;
    @(posedge clock_i) disable iff (sys_rst_i)
      pio_cmd_i && q_ff.mode != CMAG_REMOTE |=> !pio_cmd_ok_o;
  endproperty
  a_pio_block: assert property (p_pio_block) else $error("pio pass");

  // Remote-disables-local stops panel changes in remote mode
  property p_rdl_block;
    @(posedge clock_i) disable iff (sys_rst_i)
      panel_i.change && q_ff.mode == CMAG_REMOTE &&
      q_ff.ctrl[CMAG_CTL_RDL] |=> !panel_ok_o;
  endproperty
  a_rdl_block: assert property (p_rdl_block) else $error("rdl pass");

  property p_pw_block;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.ctrl[CMAG_CTL_PWEN] && !q_ff.unlocked && panel_i.change |=>
        !panel_ok_o;
  endproperty
  a_pw_block: assert property (p_pw_block) else $error("pw pass");

  // Pin paths act whatever the mode
  property p_fault_in;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.fin_sync[1] && q_ff.ctrl[CMAG_CTL_FI_EN] |=> pio_fault_o;
  endproperty
  a_fault_in: assert property (p_fault_in) else $error("no fault");

  property p_inh_mute;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.inh_sync[1] && q_ff.ctrl[CMAG_CTL_INH_EN] |=> mute_o;
  endproperty
  a_inh_mute: assert property (p_inh_mute) else $error("inh no mute");

  property p_maint_ovc;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.mode == CMAG_MAINT && overcur_i |=> mute_o;
  endproperty
  a_maint_ovc: assert property (p_maint_ovc) else $error("no mute");

  // Options reply carries the strap
  property p_opt_reply;
    @(posedge clock_i) disable iff (sys_rst_i)
      ser_query_i && ser_msg_i == CMAG_MSG_OPT_QUERY |=>
        reply_o.valid && reply_o.data == {4'h0, OPT_UNITS};
  endproperty
  a_opt_reply: assert property (p_opt_reply) else $error("bad opt");

  property p_rep_idle;
    @(posedge clock_i) disable iff (sys_rst_i)
      !ser_query_i |=> !reply_o.valid;
  endproperty
  a_rep_idle: assert property (p_rep_idle) else $error("stray rep");

  // Status outputs against the selection, per mode
  property p_rem_pio;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.mode == CMAG_REMOTE |=> pio_out_o == '0;
  endproperty
  a_rem_pio: assert property (p_rem_pio) else $error("rem status");

  property p_loc_pio;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.mode == CMAG_LOCAL |=> pio_out_o == ~$past(q_ff.piosel);
  endproperty
  a_loc_pio: assert property (p_loc_pio) else $error("loc status");

  property p_mnt_pio;
    @(posedge clock_i) disable iff (sys_rst_i)
      q_ff.mode == CMAG_MAINT |=> pio_out_o == $past(q_ff.piosel);
  endproperty
  a_mnt_pio: assert property (p_mnt_pio) else $error("mnt status");

  property p_unlock;
    @(posedge clock_i) disable iff (sys_rst_i)
      ser_unlock_i |=> !q_ff.lockout;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock stuck");

  // Read data only in the cycle after a read strobe
  property p_rd_idle;
    @(posedge clock_i) disable iff (sys_rst_i)
      !rd_i |=> rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata set");

  // Every mode move leaves its event bit behind
  property p_mode_evt;
    @(posedge clock_i) disable iff (sys_rst_i)
      $changed(mode_o) |-> q_ff.irq[CMAG_EV_MODE];
  endproperty
  a_mode_evt: assert property (p_mode_evt) else $error("no mode event");

endmodule

// ---- logic/cmag_pkg.sv ----
// Purpose: Shared constants and types for the control mode access gate
// Assumes: One clock, decoded serial messages arrive as one-cycle strobes
// Notes: Mode codes and register offsets are local choices
package cmag_pkg;

  // Control mode, one-hot
  typedef enum logic [2:0] {
    CMAG_REMOTE = 3'h1,
    CMAG_LOCAL  = 3'h2,
    CMAG_MAINT  = 3'h4
  } cmag_mode_e;

  // Mode codes carried in the query reply
  localparam logic [7:0] CMAG_CODE_REMOTE = 8'h00;
  localparam logic [7:0] CMAG_CODE_LOCAL = 8'h01;
  localparam logic [7:0] CMAG_CODE_MAINT = 8'h02;

  // Serial message codes
  localparam logic [7:0] CMAG_MSG_MODE_QUERY = 8'h20;
  localparam logic [15:0] CMAG_MSG_OPT_QUERY = 16'h165A;

  // Register offsets
  localparam logic [3:0] CMAG_REG_CTRL = 4'h0;
  localparam logic [3:0] CMAG_REG_STAT = 4'h1;
  localparam logic [3:0] CMAG_REG_IRQ = 4'h2;
  localparam logic [3:0] CMAG_REG_MASK = 4'h3;
  localparam logic [3:0] CMAG_REG_PIOSEL = 4'h4;

  // Control register bits
  localparam int CMAG_CTL_RDL = 0;
  localparam int CMAG_CTL_PWEN = 1;
  localparam int CMAG_CTL_PWSET = 2;
  localparam int CMAG_CTL_FI_EN = 3;
  localparam int CMAG_CTL_INH_EN = 4;
  localparam int CMAG_CTL_W = 5;

  // Interrupt event bits
  localparam int CMAG_EV_MODE = 0;
  localparam int CMAG_EV_REJ = 1;
  localparam int CMAG_EV_MUTE = 2;
  localparam int CMAG_EV_W = 3;

  localparam int CMAG_PIO_W = 4;

  // Panel request bundle
  typedef struct packed {
    logic key_inc;
    logic key_dec;
    logic sel_maint;
    logic change;
    logic pw_ok;
    logic pw_relock;
  } cmag_panel_s;

  // Reply to serial queries
  typedef struct packed {
    logic valid;
    logic [15:0] msg;
    logic [7:0] data;
  } cmag_reply_s;

  // Whole module state
  typedef struct packed {
    cmag_mode_e mode;
    logic lockout;
    logic unlocked;
    logic inh_latch;
    logic [CMAG_CTL_W-1:0] ctrl;
    logic [CMAG_PIO_W-1:0] piosel;
    logic [CMAG_EV_W-1:0] irq;
    logic [CMAG_EV_W-1:0] mask;
    logic [31:0] rdata;
    cmag_reply_s reply;
    logic ser_ok;
    logic pio_ok;
    logic pan_ok;
    logic mute;
    logic [CMAG_PIO_W-1:0] pio_out;
    logic pio_flt;
    logic pio_rpt;
    logic [1:0] inh_sync;
    logic [1:0] fin_sync;
  } cmag_state_s;

endpackage

// ---- verif/cmag_remote_model.sv ----
// Purpose: Remote monitoring system model on the serial side
// Assumes: Strobes launch right after a rising clock edge
// Notes: Idle message bus shows the inverse of the last code sent
`timescale 1ns/1ps
module cmag_remote_model (
  input wire logic clock_i, // System clock
  output logic cmd_o,       // Control command strobe
  output logic lock_o,      // Local lockout strobe
  output logic unlock_o,    // Lockout removal strobe
  output logic query_o,     // Query strobe
  output logic [15:0] msg_o // Query code
);
  // Quiet bus at time zero
  initial begin
    {cmd_o, lock_o, unlock_o, query_o} = 4'h0;
    msg_o = 16'h0000;
  end

  // One strobe, kind 0 cmd, 1 lock, 2 unlock, 3 query without parameters
  task automatic send(input int kind, input logic [15:0] msg);
    @(posedge clock_i);
    cmd_o <= (kind == 0);
    lock_o <= (kind == 1);
    unlock_o <= (kind == 2);
    query_o <= (kind == 3);
    msg_o <= msg;
    @(posedge clock_i);
    {cmd_o, lock_o, unlock_o, query_o} <= 4'h0;
    msg_o <= ~msg; // Stale code never looks valid
    #1;
  endtask
endmodule

// ---- verif/control_mode_access_gate_test.sv ----
// Purpose: Self-checking bench for the control mode access gate
// Assumes: Registered answers one cycle after each strobe
// Notes: Each scenario starts from a fresh reset
`timescale 1ns/1ps
module control_mode_access_gate_test;
  import cmag_pkg::*;
  localparam logic [3:0] OPT = 4'hA;
  localparam int K_INC = 5, K_DEC = 4, K_MNT = 3, K_CHG = 2, K_PW = 1;
  localparam int K_RLK = 0;
  logic clock_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic irq_o, panel_present_i = 1, ser_cmd_i, ser_lockout_i;
  logic ser_unlock_i, ser_query_i, pio_cmd_i = 0, pio_inhibit_i = 0;
  logic pio_fault_in_i = 0, thermal_i = 0, overcur_i = 0;
  logic fault_any_i = 0, mute_clear_i = 0, ser_cmd_ok_o, pio_cmd_ok_o;
  logic panel_ok_o, mute_o, pio_fault_o, pio_fault_rpt_o;
  logic [15:0] ser_msg_i;
  logic [CMAG_PIO_W-1:0] pio_out_o;
  cmag_panel_s panel_i = '0;
  cmag_reply_s reply_o;
  cmag_mode_e mode_o;
  int n_fail = 0, num_checks = 0, cyc = 0;

  // 100 MHz clock
  always #5 clock_i = ~clock_i;

  cmag_gate #(.OPT_UNITS(OPT)) DUT (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .panel_present_i(panel_present_i), .panel_i(panel_i),
    .ser_cmd_i(ser_cmd_i), .ser_lockout_i(ser_lockout_i),
    .ser_unlock_i(ser_unlock_i), .ser_query_i(ser_query_i),
    .ser_msg_i(ser_msg_i), .pio_cmd_i(pio_cmd_i),
    .pio_inhibit_i(pio_inhibit_i), .pio_fault_in_i(pio_fault_in_i),
    .thermal_i(thermal_i), .overcur_i(overcur_i),
    .fault_any_i(fault_any_i), .mute_clear_i(mute_clear_i),
    .reply_o(reply_o), .ser_cmd_ok_o(ser_cmd_ok_o),
    .pio_cmd_ok_o(pio_cmd_ok_o), .panel_ok_o(panel_ok_o),
    .mute_o(mute_o), .pio_fault_o(pio_fault_o),
    .pio_fault_rpt_o(pio_fault_rpt_o), .pio_out_o(pio_out_o),
    .mode_o(mode_o));

  cmag_remote_model rem (.clock_i(clock_i), .cmd_o(ser_cmd_i),
    .lock_o(ser_lockout_i), .unlock_o(ser_unlock_i),
    .query_o(ser_query_i), .msg_o(ser_msg_i));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, whole run needs well under this
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // Reset held two cycles; pins put back to rest at the same edge that raises it
  task automatic rst();
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    {thermal_i, overcur_i, pio_inhibit_i, pio_fault_in_i, fault_any_i,
     mute_clear_i} <= 6'h00;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic pan(input int b);
    @(posedge clock_i);
    panel_i <= cmag_panel_s'(6'h01 << b);
    @(posedge clock_i);
    panel_i <= '0;
    #1;
  endtask

  task automatic pio_cmd(input logic e);
    @(posedge clock_i);
    pio_cmd_i <= 1'b1;
    @(posedge clock_i);
    pio_cmd_i <= 1'b0;
    #1 chk("pio_ok", e, pio_cmd_ok_o);
  endtask

  // Ask for a message and compare reply contents
  task automatic query(input logic [15:0] m, input logic [7:0] e);
    rem.send(3, m);
    chk("reply_valid", 1, reply_o.valid);
    chk("reply_msg", m, reply_o.msg);
    chk("reply_data", e, reply_o.data);
  endtask

  task automatic t_remote();
    rst();
    rem.send(0, 16'h0000);
    chk("ser_ok", 1, ser_cmd_ok_o);
    chk("mode", CMAG_REMOTE, mode_o);
    pio_cmd(1'b1);
    query(16'h0020, CMAG_CODE_REMOTE);
    query(16'h165A, {4'h0, OPT});
    wr(CMAG_REG_CTRL, 32'h1 << CMAG_CTL_RDL);
    pan(K_CHG);
    chk("panel_ok", 0, panel_ok_o);
    wr(CMAG_REG_CTRL, 32'h0);
    pan(K_CHG);
    chk("panel_ok", 1, panel_ok_o);
  endtask

  task automatic t_local();
    rst();
    wr(CMAG_REG_CTRL, 32'h18);
    wr(CMAG_REG_PIOSEL, 32'h5);
    pan(K_INC);
    chk("mode", CMAG_LOCAL, mode_o);
    query(16'h0020, CMAG_CODE_LOCAL);
    rem.send(0, 16'h0000);
    chk("ser_ok", 0, ser_cmd_ok_o);
    chk("mode", CMAG_LOCAL, mode_o);
    pio_cmd(1'b0);
    pan(K_CHG);
    chk("panel_ok", 1, panel_ok_o);
    chk("pio_out", 4'hA, pio_out_o);
    @(posedge clock_i);
    {pio_inhibit_i, pio_fault_in_i, fault_any_i} <= 3'h7;
    repeat (6) @(posedge clock_i);
    chk("mute", 1, mute_o);
    chk("pio_fault", 1, pio_fault_o);
    chk("fault_rpt", 1, pio_fault_rpt_o);
    pan(K_DEC);
    chk("mode", CMAG_REMOTE, mode_o);
  endtask

  // Thermal, overcurrent, inhibit each mute; inhibit mute is kept
  task automatic t_maint();
    for (int i = 0; i < 3; i++) begin
      rst();
      wr(CMAG_REG_CTRL, 32'h1 << CMAG_CTL_INH_EN);
      wr(CMAG_REG_PIOSEL, 32'h5);
      pan(K_MNT);
      chk("mode", CMAG_MAINT, mode_o);
      query(16'h0020, CMAG_CODE_MAINT);
      rem.send(0, 16'h0000);
      chk("ser_ok", 0, ser_cmd_ok_o);
      pio_cmd(1'b0);
      chk("pio_out", 4'h5, pio_out_o);
      @(posedge clock_i);
      fault_any_i <= 1'b1;
      {thermal_i, overcur_i, pio_inhibit_i} <= 3'h4 >> i;
      repeat (6) @(posedge clock_i);
      chk("fault_rpt", 0, pio_fault_rpt_o);
      chk("mute", 1, mute_o);
      fault_any_i <= 1'b0;
      {thermal_i, overcur_i, pio_inhibit_i} <= 3'h0;
      repeat (6) @(posedge clock_i);
      if (i == 2) begin
        chk("mute_kept", 1, mute_o);
        mute_clear_i <= 1'b1;
        pan(K_CHG);
        chk("mute_clr", 0, mute_o);
        @(posedge clock_i);
        mute_clear_i <= 1'b0;
      end else begin
        chk("mute_free", 0, mute_o);
      end
    end
  endtask

  task automatic t_nopanel();
    rst();
    pan(K_INC);
    @(posedge clock_i);
    panel_present_i <= 1'b0;
    @(posedge clock_i);
    #1 chk("mode", CMAG_REMOTE, mode_o);
    pan(K_INC);
    pan(K_MNT);
    chk("mode", CMAG_REMOTE, mode_o);
    @(posedge clock_i);
    panel_present_i <= 1'b1;
  endtask

  task automatic t_lock();
    rst();
    rem.send(1, 16'h0000);
    pan(K_CHG);
    chk("panel_ok", 0, panel_ok_o);
    pan(K_INC);
    chk("mode", CMAG_REMOTE, mode_o);
    rem.send(2, 16'h0000);
    pan(K_CHG);
    chk("panel_ok", 1, panel_ok_o);
    rem.send(1, 16'h0000);
    wr(CMAG_REG_CTRL, 32'h1 << CMAG_CTL_PWSET);
    pan(K_PW);
    pan(K_CHG);
    chk("panel_ok", 1, panel_ok_o);
    rst();
    wr(CMAG_REG_CTRL, 32'h6);
    pan(K_CHG);
    chk("panel_ok", 0, panel_ok_o);
    pan(K_PW);
    pan(K_CHG);
    chk("panel_ok", 1, panel_ok_o);
    pan(K_RLK);
    pan(K_CHG);
    chk("panel_ok", 0, panel_ok_o);
  endtask

  // Mode-change event, masked and unmasked, cleared by read
  task automatic t_irq();
    logic [31:0] d;
    rst();
    pan(K_INC);
    chk("irq_masked", 0, irq_o);
    wr(CMAG_REG_MASK, 32'h1 << CMAG_EV_MODE);
    chk("irq", 1, irq_o);
    rd(CMAG_REG_IRQ, d);
    chk("irq_reg", 32'h1, d);
    #10 chk("irq_clr", 0, irq_o);
    rd(4'hF, d);
    chk("unmapped", 32'h0, d);
  endtask

  initial begin
    t_remote();
    t_local();
    t_maint();
    t_nopanel();
    t_lock();
    t_irq();
    report_and_stop();
  end
endmodule
